// >>> src/flash_seq_regs.vh
// Constants for the serial flash program, erase and wrap sequencer.
// Assumes an includer that uses them by macro name.
//
// Operation
// - Wrap setup frame is opcode, 24 dummy bits, wrap byte; device latches it.
// - Stored wrap setting applies to later quad reads in any page, except in four-lane command mode.
// - Bit 4 low enables wrap; bits 6-5 pick 8/16/32/64 bytes.
// - Single-lane program is opcode, three address bytes, one or more data bytes.
// - Data passing the page end continues at offset zero of that page.
// - Over 256 data bytes, only the last 256 are programmed.
// - Under 256 data bytes, other bytes of the page stay untouched.
// - Program runs only when chip select rises on a data byte boundary.
// - Program and erase need the write enable latch set first.
// - Valid frame end starts timed cycle, busy high until done, latch cleared.
// - Status stays readable while a timed cycle runs.
// - Program to a protected page is not executed.
// - Quad program moves address and data on four lanes, needs quad enable.
// - Sector erase clears the whole sector holding the address.
// - Erase runs only when chip select rises right after third address byte.
// - Half block erase clears the whole 32KB block holding the address.
// - Full block erase clears the whole 64KB block holding the address.
// - Erase of a protected region is not executed.
// - Wrap setting does not apply in four-lane command mode.
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_WRAP_SET 8'h77
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_FULL_BLOCK_ERASE 8'hD8
`define WRAP_RESET 3'h1
`define WRAP_DIS_BIT 4
`define WRAP_LEN_MSB 6
`define WRAP_LEN_LSB 5
`define CMD_END_BYTES 4'h1
`define ERASE_END_BYTES 4'h4
`define WRAP_END_BYTES 4'h5
`define PROG_MIN_BYTES 4'h5
`define ERASE_SIZE_SECTOR 2'h0
`define ERASE_SIZE_HALF 2'h1
`define ERASE_SIZE_FULL 2'h2
`define SECTOR_MASK 24'hFFF000
`define HALF_BLOCK_MASK 24'hFF8000
`define FULL_BLOCK_MASK 24'hFF0000
`define TOTAL_BLOCKS 8'h80
`define CLK_MHZ 20
`define PROG_TIME_US 400
`define SECTOR_ERASE_MS 50
`define HALF_BLOCK_ERASE_MS 150
`define FULL_BLOCK_ERASE_MS 300
`endif

// >>> src/pin_sync2.v
// Two-flop synchroniser for pins entering the system clock domain.
// Assumes asynchronous pins and a free running i_clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 #(
    parameter W = 6
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Pins and synchronised copies
    input wire [W-1:0] i_pins,
    output reg [W-1:0] o_pins
);
    reg [W-1:0] meta_q;
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_q <= {W{1'b1}};
            o_pins <= {W{1'b1}};
        end else begin
            meta_q <= i_pins;
            o_pins <= meta_q;
        end
    end
endmodule // pin_sync2
`default_nettype wire

// >>> src/word_buffer.v
// Shift-style buffer; head entry and its valid are flops.
// Assumes source and sink on i_clk; push is ignored while full.
`timescale 1ns/100ps
`default_nettype none
module word_buffer #(
    parameter W = 32,
    parameter DEPTH = 2
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Fill side
    input wire i_valid,
    input wire [W-1:0] i_data,
    output wire o_ready,
    // Drain side
    output wire o_valid,
    output wire [W-1:0] o_data,
    input wire i_ready
);
    wire [DEPTH:0] vld_w;
    wire [W-1:0] ent_w [0:DEPTH];
    wire push = i_valid & ~vld_w[DEPTH-1];
    wire pop = vld_w[0] & i_ready;
    assign o_ready = ~vld_w[DEPTH-1];
    assign o_valid = vld_w[0];
    assign o_data = ent_w[0];
    // Always-empty slot past the tail
    assign vld_w[DEPTH] = 1'b0;
    assign ent_w[DEPTH] = {W{1'b0}};
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            reg v_q;
            reg [W-1:0] e_q;
            wire prev_v;
            // Slot filled next: shifted neighbour or the incoming word
            wire sh_v = pop ? vld_w[g+1] : vld_w[g];
            if (g == 0) begin : g_head
                assign prev_v = 1'b1;
            end else begin : g_tail
                assign prev_v = pop ? vld_w[g] : vld_w[g-1];
            end
            wire take = push & ~sh_v & prev_v;
            assign vld_w[g] = v_q;
            assign ent_w[g] = e_q;
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    v_q <= 1'b0;
                end else begin
                    v_q <= sh_v | take;
                end
            end
            always @(posedge i_clk) begin
                if (take) begin
                    e_q <= i_data;
                end else if (pop) begin
                    e_q <= ent_w[g+1];
                end
            end
        end
    endgenerate
endmodule // word_buffer
`default_nettype wire

// >>> src/serial_flash_program_erase_wrap.v
// Command sequencer for wrap setup, page program and erase in a serial flash.
// Assumes link pins asynchronous to i_clk, configuration inputs steady, and serial clock well below i_clk/4.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.vh"
module serial_flash_program_erase_wrap #(
    parameter PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ,
    parameter SECTOR_CYCLES = `SECTOR_ERASE_MS * 1000 * `CLK_MHZ,
    parameter HALF_CYCLES = `HALF_BLOCK_ERASE_MS * 1000 * `CLK_MHZ,
    parameter FULL_CYCLES = `FULL_BLOCK_ERASE_MS * 1000 * `CLK_MHZ,
    parameter BUF_DEPTH = 2
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Serial link pins
    input wire i_chip_select_n,
    input wire i_serial_clock,
    input wire i_quad_lane_0,
    input wire i_quad_lane_1,
    input wire i_quad_lane_2,
    input wire i_quad_lane_3,
    // Configuration
    input wire i_quad_enable_bit,
    input wire i_four_lane_command_mode,
    input wire [4:0] i_block_protect_bits,
    // Array program stream
    output wire o_prog_valid,
    output wire [23:0] o_prog_addr,
    output wire [7:0] o_prog_data,
    input wire i_prog_ready,
    // Array erase request
    output reg o_erase_start,
    output reg [23:0] o_erase_addr,
    output reg [1:0] o_erase_size,
    // Status
    output reg o_write_in_progress,
    output reg o_write_enable_latch,
    output reg o_wrap_enable,
    output reg [1:0] o_wrap_length
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PROG = 2'h1;
    localparam ST_ERASE = 2'h2;
    localparam [31:0] PROG_LOAD = PROG_CYCLES;
    localparam [31:0] SECTOR_LOAD = SECTOR_CYCLES;
    localparam [31:0] HALF_LOAD = HALF_CYCLES;
    localparam [31:0] FULL_LOAD = FULL_CYCLES;

    // Region lock check by 64KB block index
    function prot_hit;
        input [23:0] a;
        input [4:0] bp;
        reg [7:0] n;
        begin
            n = 8'h00;
            if (bp[2:0] == 3'h7) begin
                n = `TOTAL_BLOCKS;
            end else if (bp[2:0] != 3'h0) begin
                n = 8'h01 << (bp[2:0] - 3'h1);
            end
            if (bp[4]) begin
                prot_hit = {1'b0, a[22:16]} < n;
            end else begin
                prot_hit = {1'b0, a[22:16]} >= (`TOTAL_BLOCKS - n);
            end
        end
    endfunction

    // Program opcode decode, single or quad lane
    function is_program;
        input [7:0] op;
        begin
            is_program = (op == `OP_PAGE_PROG) | (op == `OP_QUAD_PROG);
        end
    endfunction

    // Pin synchronisation
    wire [5:0] pin_s;
    pin_sync2 #(.W(6)) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pins({i_chip_select_n, i_serial_clock, i_quad_lane_3,
                 i_quad_lane_2, i_quad_lane_1, i_quad_lane_0}),
        .o_pins(pin_s)
    );
    wire cs_n_s = pin_s[5];
    wire sclk_s = pin_s[4];
    wire [3:0] lanes_s = pin_s[3:0];

    reg sclk_prev_q;
    reg cs_prev_q;
    reg [7:0] sh_q;
    reg [3:0] bitcnt_q;
    reg [3:0] bcnt_q;
    reg [7:0] op_q;
    reg [23:0] addr_q;
    reg [7:0] wrap_byte_q;
    reg [2:0] wrap_q;
    reg [7:0] ptr_q;
    reg [255:0] mask_q;
    reg [7:0] page_mem [0:255];
    reg [1:0] state_q;
    reg [31:0] timer_q;
    reg [8:0] feed_q;
    reg [15:0] page_q;
    reg frame_busy_q;

    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire cs_rise = cs_n_s & ~cs_prev_q;
    wire busy = (state_q != ST_IDLE);
    wire quad_phase = i_four_lane_command_mode |
                      ((op_q == `OP_QUAD_PROG) & (bcnt_q != 4'h0));
    wire [3:0] bits_nxt = bitcnt_q + (quad_phase ? 4'h4 : 4'h1);
    wire [7:0] sh_nxt = quad_phase ? {sh_q[3:0], lanes_s} : {sh_q[6:0], lanes_s[0]};
    wire byte_done = sclk_rise & ~cs_n_s & (bits_nxt == 4'h8);
    wire is_prog_op = is_program(op_q);
    wire data_wr = byte_done & (bcnt_q >= 4'h4) & is_prog_op & ~busy;

    // Frame end decode
    wire on_boundary = (bitcnt_q == 4'h0);
    wire locked = prot_hit(addr_q, i_block_protect_bits);
    wire prog_ok = (op_q == `OP_PAGE_PROG) |
                   ((op_q == `OP_QUAD_PROG) & i_quad_enable_bit);
    wire prog_frame = prog_ok & (bcnt_q >= `PROG_MIN_BYTES) & on_boundary;
    wire erase_op = (op_q == `OP_SECTOR_ERASE) | (op_q == `OP_HALF_BLOCK_ERASE) |
                    (op_q == `OP_FULL_BLOCK_ERASE);
    wire erase_frame = erase_op & (bcnt_q == `ERASE_END_BYTES) & on_boundary;
    wire allowed = o_write_enable_latch & ~busy & ~frame_busy_q;
    wire start_prog = cs_rise & prog_frame & allowed & ~locked;
    wire start_erase = cs_rise & erase_frame & allowed & ~locked;
    wire short_cmd = cs_rise & (bcnt_q == `CMD_END_BYTES) & on_boundary & ~busy &
                     ~frame_busy_q;
    wire wrap_frame = cs_rise & (op_q == `OP_WRAP_SET) &
                      (bcnt_q == `WRAP_END_BYTES) & on_boundary;

    // Program feed into the buffer
    wire feed_live = (state_q == ST_PROG) & ~feed_q[8];
    wire feed_push = feed_live & mask_q[feed_q[7:0]];
    wire buf_ready;
    wire [31:0] buf_out;
    word_buffer #(.W(32), .DEPTH(BUF_DEPTH)) u_buf (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(feed_push),
        .i_data({page_q, feed_q[7:0], page_mem[feed_q[7:0]]}),
        .o_ready(buf_ready),
        .o_valid(o_prog_valid),
        .o_data(buf_out),
        .i_ready(i_prog_ready)
    );
    assign o_prog_addr = buf_out[31:8];
    assign o_prog_data = buf_out[7:0];

    // Frame shifter
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sclk_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
            sh_q <= 8'h00;
            bitcnt_q <= 4'h0;
            bcnt_q <= 4'h0;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            wrap_byte_q <= 8'h00;
            ptr_q <= 8'h00;
            frame_busy_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
            if (cs_n_s) begin
                frame_busy_q <= 1'b0;
            end else if (busy) begin
                frame_busy_q <= 1'b1;
            end
            if (cs_n_s) begin
                bitcnt_q <= 4'h0;
                bcnt_q <= 4'h0;
            end else if (sclk_rise) begin
                sh_q <= sh_nxt;
                bitcnt_q <= byte_done ? 4'h0 : bits_nxt;
                if (byte_done) begin
                    if (bcnt_q != 4'hF) begin
                        bcnt_q <= bcnt_q + 4'h1;
                    end
                    case (bcnt_q)
                        4'h0: op_q <= sh_nxt;
                        4'h1: addr_q[23:16] <= sh_nxt;
                        4'h2: addr_q[15:8] <= sh_nxt;
                        4'h3: begin
                            addr_q[7:0] <= sh_nxt;
                            ptr_q <= sh_nxt;
                        end
                        4'h4: wrap_byte_q <= sh_nxt;
                        default: ;
                    endcase
                    if (data_wr) begin
                        ptr_q <= ptr_q + 8'h01;
                    end
                end
            end
        end
    end

    // Page image
    always @(posedge i_clk) begin
        if (data_wr) begin
            page_mem[ptr_q] <= sh_nxt;
        end
    end

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_q <= 256'h0;
        end else if (data_wr) begin
            mask_q[ptr_q] <= 1'b1;
        end else if (cs_n_s & ~cs_rise & ~busy) begin
            mask_q <= 256'h0;
        end
    end

    // Wrap setting and status
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wrap_q <= `WRAP_RESET;
            o_wrap_enable <= 1'b0;
            o_wrap_length <= 2'h0;
            o_write_enable_latch <= 1'b0;
        end else begin
            if (wrap_frame) begin
                wrap_q <= wrap_byte_q[`WRAP_LEN_MSB:`WRAP_DIS_BIT];
            end
            o_wrap_enable <= ~wrap_q[0] & ~i_four_lane_command_mode;
            o_wrap_length <= wrap_q[2:1];
            if (start_prog | start_erase) begin
                o_write_enable_latch <= 1'b0;
            end else if (short_cmd & (op_q == `OP_WRITE_ENABLE)) begin
                o_write_enable_latch <= 1'b1;
            end else if (short_cmd & (op_q == `OP_WRITE_DISABLE)) begin
                o_write_enable_latch <= 1'b0;
            end
        end
    end

    // Timed cycle
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h0;
            feed_q <= 9'h000;
            page_q <= 16'h0000;
            o_write_in_progress <= 1'b0;
            o_erase_start <= 1'b0;
            o_erase_addr <= 24'h000000;
            o_erase_size <= 2'h0;
        end else begin
            o_erase_start <= 1'b0;
            o_write_in_progress <= busy | start_prog | start_erase;
            if (timer_q != 32'h0) begin
                timer_q <= timer_q - 32'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start_prog) begin
                        state_q <= ST_PROG;
                        timer_q <= PROG_LOAD;
                        feed_q <= 9'h000;
                        page_q <= addr_q[23:8];
                    end else if (start_erase) begin
                        state_q <= ST_ERASE;
                        o_erase_start <= 1'b1;
                        if (op_q == `OP_SECTOR_ERASE) begin
                            timer_q <= SECTOR_LOAD;
                            o_erase_size <= `ERASE_SIZE_SECTOR;
                            o_erase_addr <= addr_q & `SECTOR_MASK;
                        end else if (op_q == `OP_HALF_BLOCK_ERASE) begin
                            timer_q <= HALF_LOAD;
                            o_erase_size <= `ERASE_SIZE_HALF;
                            o_erase_addr <= addr_q & `HALF_BLOCK_MASK;
                        end else begin
                            timer_q <= FULL_LOAD;
                            o_erase_size <= `ERASE_SIZE_FULL;
                            o_erase_addr <= addr_q & `FULL_BLOCK_MASK;
                        end
                    end
                end
                ST_PROG: begin
                    if (feed_live & (~feed_push | buf_ready)) begin
                        feed_q <= feed_q + 9'h001;
                    end
                    if ((timer_q <= 32'h1) & feed_q[8] & ~o_prog_valid) begin
                        state_q <= ST_IDLE;
                        timer_q <= 32'h0;
                    end
                end
                ST_ERASE: begin
                    if (timer_q <= 32'h1) begin
                        state_q <= ST_IDLE;
                        timer_q <= 32'h0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // serial_flash_program_erase_wrap
`default_nettype wire

// >>> tb/flash_seq_chk.sv
// Checker for the flash sequencer outputs against its pins.
// Assumes binding onto the sequencer top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module flash_seq_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Link and stream
    input wire logic i_chip_select_n,
    input wire logic i_prog_ready,
    input wire logic o_prog_valid,
    input wire logic [23:0] o_prog_addr,
    input wire logic [7:0] o_prog_data,
    // Erase and status
    input wire logic o_erase_start,
    input wire logic [23:0] o_erase_addr,
    input wire logic [1:0] o_erase_size,
    input wire logic o_write_in_progress,
    input wire logic o_write_enable_latch,
    input wire logic o_wrap_enable
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_erase_pulse_once: assert property (o_erase_start |=> !o_erase_start)
        else $error("erase start longer than one cycle");
    a_erase_starts_busy: assert property (o_erase_start |->
        $rose(o_write_in_progress) && !o_write_enable_latch)
        else $error("erase start without busy rise");
    a_busy_needs_latch: assert property ($rose(o_write_in_progress) |->
        $past(o_write_enable_latch)) else $error("busy rose without latch");
    a_erase_region_aligned: assert property (o_erase_start |->
        (o_erase_size == 2'h0 && o_erase_addr[11:0] == 12'h000) ||
        (o_erase_size == 2'h1 && o_erase_addr[14:0] == 15'h0000) ||
        (o_erase_size == 2'h2 && o_erase_addr[15:0] == 16'h0000))
        else $error("erase region misaligned");
    a_word_held: assert property (o_prog_valid && !i_prog_ready |=> o_prog_valid &&
        $stable(o_prog_addr) && $stable(o_prog_data)) else $error("word dropped");
    a_word_while_busy: assert property (o_prog_valid |-> o_write_in_progress)
        else $error("word outside busy");
    a_word_order_page: assert property (o_prog_valid && $past(o_prog_valid) &&
        $past(i_prog_ready) && $past(o_write_in_progress) |->
        o_prog_addr[23:8] == $past(o_prog_addr[23:8]) &&
        o_prog_addr[7:0] > $past(o_prog_addr[7:0])) else $error("word order");
    a_done_clean: assert property ($fell(o_write_in_progress) |->
        !o_write_enable_latch && !o_prog_valid) else $error("busy fell early");
    a_latch_when_idle: assert property ($rose(o_write_enable_latch) |->
        i_chip_select_n && !o_write_in_progress) else $error("latch set while busy");
    a_wrap_at_frame_end: assert property ($changed(o_wrap_enable) |-> i_chip_select_n)
        else $error("wrap changed inside frame");
endmodule // flash_seq_chk
bind serial_flash_program_erase_wrap flash_seq_chk flash_seq_chk_i (.i_clk(i_clk),
    .i_reset(i_reset), .i_chip_select_n(i_chip_select_n), .i_prog_ready(i_prog_ready),
    .o_prog_valid(o_prog_valid), .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data),
    .o_erase_start(o_erase_start), .o_erase_addr(o_erase_addr),
    .o_erase_size(o_erase_size), .o_write_in_progress(o_write_in_progress),
    .o_write_enable_latch(o_write_enable_latch), .o_wrap_enable(o_wrap_enable));
`default_nettype wire

// >>> tb/flash_host_model.sv
// Host controller model driving chip select, link clock and lanes.
// Assumes the bench calls frame hierarchically, one frame at a time.
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // Clock
    input wire logic i_clk,
    // Link pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic [3:0] o_lanes
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_lanes = 4'hA;
    end
    // One link clock period of eight i_clk cycles, 400 ns
    task automatic pulse(input logic [3:0] v);
        o_lanes <= v;
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b0;
    endtask
    // Bytes msb first, quad lanes after opcode, then stray bits
    task automatic frame(input logic [7:0] q[$], input bit quad, input int extra);
        int i;
        int k;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (i = 0; i < q.size(); i++) begin
            if (quad && i > 0) begin
                pulse(q[i][7:4]);
                pulse(q[i][3:0]);
            end else begin
                for (k = 7; k >= 0; k--) pulse({3'h5, q[i][k]});
            end
        end
        for (k = 0; k < extra; k++) pulse(4'h0);
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_lanes <= ~o_lanes;
        repeat (20) @(posedge i_clk);
    endtask
endmodule // flash_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the flash sequencer.
// Assumes the host model drives the link; bench sinks the program stream.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic qen = 1'b0;
    logic four_lane = 1'b0;
    logic [4:0] bp = 5'h00;
    logic ready = 1'b0;
    logic cs_n, sclk, valid, estart, write_in_progress, write_enable_latch, wen;
    logic [3:0] lanes;
    logic [23:0] paddr, eaddr;
    logic [7:0] pdata;
    logic [1:0] esize, wlen;
    logic [31:0] words[$];
    logic [31:0] ew[$];
    logic [7:0] q[$];
    int n_mismatch = 0;
    int checks = 0;
    int n_erase = 0;
    int i;
    always #25 i_clk = ~i_clk;
    flash_host_model flash_host_model_i (.i_clk(i_clk), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_lanes(lanes));
    serial_flash_program_erase_wrap #(.PROG_CYCLES(40), .SECTOR_CYCLES(50),
        .HALF_CYCLES(60), .FULL_CYCLES(400)) serial_flash_program_erase_wrap_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_chip_select_n(cs_n), .i_serial_clock(sclk),
        .i_quad_lane_0(lanes[0]), .i_quad_lane_1(lanes[1]), .i_quad_lane_2(lanes[2]),
        .i_quad_lane_3(lanes[3]), .i_quad_enable_bit(qen), .i_four_lane_command_mode(four_lane),
        .i_block_protect_bits(bp), .o_prog_valid(valid), .o_prog_addr(paddr),
        .o_prog_data(pdata), .i_prog_ready(ready), .o_erase_start(estart),
        .o_erase_addr(eaddr), .o_erase_size(esize), .o_write_in_progress(write_in_progress),
        .o_write_enable_latch(write_enable_latch), .o_wrap_enable(wen), .o_wrap_length(wlen));
    // Array sink stalls every other cycle
    always @(posedge i_clk) begin
        ready <= ~ready;
        if (valid === 1'b1 && ready === 1'b1) words.push_back({paddr, pdata});
        if (estart === 1'b1) n_erase <= n_erase + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic idle;
        int n;
        n = 0;
        while (write_in_progress !== 1'b0 && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (write_in_progress !== 1'b0) begin
            chk(32'h1, 32'h0);
            print_verdict;
        end
    endtask
    task automatic op(input logic [7:0] f[$], input bit quad, input int extra, input bit b);
        flash_host_model_i.frame(f, quad, extra);
        chk(32'(write_in_progress), 32'(b));
        idle;
    endtask
    task automatic write_enable_cmd;
        flash_host_model_i.frame('{8'h06}, 0, 0);
        chk(32'(write_enable_latch), 32'h1);
    endtask
    task automatic chk_words(input logic [31:0] e[$]);
        int k;
        chk(32'(words.size()), 32'(e.size()));
        for (k = 0; k < e.size() && k < words.size(); k++) chk(words[k], e[k]);
        words.delete();
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(32'(wen), 32'h0);
        for (i = 0; i < 8; i++) begin
            flash_host_model_i.frame('{8'h77, 8'h00, 8'h00, 8'h00, 8'(i << 4)}, 0, 0);
            chk(32'(wen), i[0] ? 32'h0 : 32'h1);
            if (!i[0]) chk(32'(wlen), 32'(i[2:1]));
        end
        op('{8'h02, 8'h00, 8'h01, 8'h10, 8'h55}, 0, 0, 0);
        write_enable_cmd;
        op('{8'h02, 8'h00, 8'h01, 8'hFE, 8'hA1, 8'hA2, 8'hA3}, 0, 0, 1);
        chk(32'(write_enable_latch), 32'h0);
        chk_words('{32'h000100A3, 32'h0001FEA1, 32'h0001FFA2});
        write_enable_cmd;
        q = '{8'h02, 8'h00, 8'h02, 8'h00};
        for (i = 0; i < 260; i++) q.push_back(8'(i + (i >> 8)));
        op(q, 0, 0, 1);
        q.delete();
        for (i = 0; i < 256; i++) ew.push_back({24'h000200 + 24'(i), 8'(i + (i < 4))});
        chk_words(ew);
        ew.delete();
        write_enable_cmd;
        op('{8'h02, 8'h00, 8'h01, 8'h00, 8'h11}, 0, 3, 0);
        op('{8'h20, 8'h00, 8'h30, 8'h00}, 0, 5, 0);
        for (i = 0; i < 3; i++) begin
            if (i > 0) write_enable_cmd;
            q = '{8'h20, 8'h12, 8'h34, 8'h56};
            q[0] = i == 0 ? 8'h20 : (i == 1 ? 8'h52 : 8'hD8);
            flash_host_model_i.frame(q, 0, 0);
            chk(32'(write_in_progress), 32'h1);
            chk(32'(eaddr), i == 0 ? 32'h123000 : 32'h120000);
            chk(32'(esize), 32'(i));
            chk(32'(n_erase), 32'(i + 1));
            if (i == 2) begin
                flash_host_model_i.frame('{8'h06}, 0, 0);
                chk(32'(write_enable_latch), 32'h0);
                chk(32'(write_in_progress), 32'h1);
            end
            idle;
        end
        bp <= 5'h01;
        write_enable_cmd;
        op('{8'h20, 8'h7F, 8'h12, 8'h34}, 0, 0, 0);
        op('{8'h02, 8'h7F, 8'h00, 8'h00, 8'h11}, 0, 0, 0);
        bp <= 5'h00;
        op('{8'h32, 8'h00, 8'h03, 8'h10, 8'h5A}, 1, 0, 0);
        qen <= 1'b1;
        op('{8'h32, 8'h00, 8'h03, 8'h10, 8'h5A}, 1, 0, 1);
        chk_words('{32'h0003105A});
        flash_host_model_i.frame('{8'h77, 8'h00, 8'h00, 8'h00, 8'h40}, 0, 0);
        chk(32'(wen), 32'h1);
        four_lane <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(32'(wen), 32'h0);
        chk(32'(wlen), 32'h2);
        four_lane <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(32'(wen), 32'h1);
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
